// File: sdp_cfg.svh
// Contract
// - format 1101, cover length zero: currents and covers
// - format 1100, cover length zero: covers, automatic only
// - poll spacing is two-power exponent times block time
// - step/direction mode sends own polling datagrams
// - step/direction mode sends scaling datagrams
// - every datagram is forty bits long
// - cover sent once, done event after transfer
// - cover reply split into high and low registers
// - current mode: done event after current datagrams
// - done event after polling datagrams too
// - restriction bit limits done event to covers
`ifndef SDP_CFG_SVH
`define SDP_CFG_SVH

`define SDP_ADDR_CONFIG      8'h04
`define SDP_ADDR_TIMING      8'h10
`define SDP_ADDR_COVER_LOW   8'h6C
`define SDP_ADDR_COVER_HIGH  8'h6D

`define SDP_CONFIG_RESET     32'h0000_0000
`define SDP_TIMING_RESET     32'h0000_0000

`define SDP_FMT_LSB          0
`define SDP_FMT_MSB          3
`define SDP_SCALE_EN_BIT     5
`define SDP_POLL_DIS_BIT     6
`define SDP_POLL_EXP_LSB     8
`define SDP_POLL_EXP_MSB     11
`define SDP_DONE_COVERS_BIT  12
`define SDP_COVER_LEN_LSB    13
`define SDP_COVER_LEN_MSB    19

`define SDP_FMT_SPI_MODE     4'hD
`define SDP_FMT_SD_MODE      4'hC

`define SDP_DGRAM_BITS       40
`define SDP_ADDR_BITS        8
`define SDP_POLL_ADDR        8'h6F

`endif

// File: sdp_chk_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sdp_chk #(parameter int GAP_CYCLES = 8) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // spi pins
  input wire logic sckOut,
  input wire logic csN,
  input wire logic mosiOut,
  // streams and status
  input wire logic coverDone,
  input wire logic currentValid,
  input wire logic currentReady,
  input wire logic scaleReady,
  input wire logic spiMode,
  input wire logic sdMode,
  input wire logic busy
);
  logic       sck_q;
  logic [7:0] rise_q;
  logic [7:0] gap_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // sck rising edges in the open frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_q  <= 1'b0;
      rise_q <= 8'h00;
    end else begin
      sck_q  <= sckOut;
      rise_q <= csN ? 8'h00 : rise_q + 8'(sckOut && !sck_q);
    end
  end
  // idle cycles since the last frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) gap_q <= 8'hFF;
    else if (!csN) gap_q <= 8'h00;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  end
  property p_len; $rose(csN) |-> rise_q == 8'h28; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_idle; csN |-> !sckOut; endproperty
  a_idle: assert property (p_idle) else $error("sck idle");
  property p_msb; !csN && $changed(mosiOut) |-> $fell(sckOut) || $fell(csN); endproperty
  a_msb: assert property (p_msb) else $error("mosi edge");
  property p_done; coverDone |-> csN && !$past(csN); endproperty
  a_done: assert property (p_done) else $error("done timing");
  property p_take; currentValid && currentReady |-> ##[1:2] !csN; endproperty
  a_take: assert property (p_take) else $error("no start");
  property p_cur; currentReady |-> spiMode && !sdMode && !busy; endproperty
  a_cur: assert property (p_cur) else $error("current mode");
  property p_scale; scaleReady |-> sdMode && !busy; endproperty
  a_scale: assert property (p_scale) else $error("scale mode");
  property p_gap; $fell(csN) |-> gap_q + 1 >= GAP_CYCLES; endproperty
  a_gap: assert property (p_gap) else $error("gap short");
endmodule
bind sdp_spi_datagram_port sdp_chk #(.GAP_CYCLES(GAP_CYCLES)) u_sdp_chk (
  .clk(clk), .rst(rst), .sckOut(sckOut), .csN(csN), .mosiOut(mosiOut),
  .coverDone(coverDone), .currentValid(currentValid), .currentReady(currentReady),
  .scaleReady(scaleReady), .spiMode(spiMode), .sdMode(sdMode), .busy(busy)
);
`default_nettype wire

// File: sdp_drv_model.sv
`timescale 1ns/100ps
`default_nettype none
module sdp_drv_model (
  // clock and spi pins
  input  wire logic clk,
  input  wire logic sckOut,
  input  wire logic csN,
  input  wire logic mosiOut,
  output logic      misoIn
);
  logic        sck_q = 1'b0;
  logic        cs_q = 1'b1;
  logic [39:0] tx;
  logic [39:0] rx;
  logic [39:0] lastRx;
  int          bits;
  int          frames = 0;
  initial misoIn = 1'b0;
  // reply carries the frame number so a stale capture shows
  always @(posedge clk) begin
    sck_q <= sckOut;
    cs_q <= csN;
    if (cs_q && !csN) begin
      tx = {8'hA5 ^ frames[7:0], 24'h3C_960F, frames[7:0]};
      bits = 0;
    end else if (!csN && sckOut && !sck_q) begin
      rx = {rx[38:0], mosiOut};
      bits++;
    end else if (!csN && !sckOut && sck_q) begin
      tx = tx << 1;
    end else if (!cs_q && csN && bits == 40) begin
      lastRx = rx;
      frames++;
    end
    misoIn <= csN ? ~misoIn : tx[39];
  end
endmodule
`default_nettype wire

// File: sdp_pkg.sv
package sdp_pkg;

  typedef enum logic [1:0] {
    SDP_IDLE,
    SDP_SHIFT,
    SDP_GAP
  } sdp_state_t;

  typedef enum logic [1:0] {
    SDP_KIND_COVER,
    SDP_KIND_CURRENT,
    SDP_KIND_SCALE,
    SDP_KIND_POLL
  } sdp_kind_t;

endpackage

// File: sdp_spi_datagram_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdp_cfg.svh"

module sdp_spi_datagram_port
  import sdp_pkg::*;
#(
  parameter int SCK_HALF    = 4,
  parameter int BLOCK_TIME  = 64,
  parameter int GAP_CYCLES  = 8,
  parameter int REPLY_WIDTH = `SDP_DGRAM_BITS
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // register port
  input  wire logic                    regWr,
  input  wire logic [7:0]              regAddr,
  input  wire logic [31:0]             regWrData,
  output logic      [31:0]             regRdData,
  // step timing fields toward the step generator
  output logic      [31:0]             stepDirTiming,
  // current datagrams from the sequencer
  input  wire logic                    currentValid,
  output logic                         currentReady,
  input  wire logic [39:0]             currentData,
  // automatic scaling datagrams
  input  wire logic                    scaleValid,
  output logic                         scaleReady,
  input  wire logic [39:0]             scaleData,
  // driver replies
  output logic                         replyValid,
  input  wire logic                    replyReady,
  output logic      [REPLY_WIDTH-1:0]  replyData,
  // events and status
  output logic                         coverDone,
  output logic                         spiMode,
  output logic                         sdMode,
  output logic                         busy,
  // spi pins, miso is the one input
  output logic                         sckOut,
  output logic                         csN,
  output logic                         mosiOut,
  input  wire logic                    misoIn
);

  localparam int DG     = `SDP_DGRAM_BITS;
  localparam int BITW   = $clog2(DG + 1);
  localparam int DIVW   = $clog2(SCK_HALF + 1);
  localparam int GAPW   = $clog2(GAP_CYCLES + 1);
  localparam int PCNTW  = $clog2(BLOCK_TIME + 1) + 16;

  initial begin
    if (SCK_HALF < 3) $error("SCK_HALF below 3 cannot sample the synchronised input");
    if (BLOCK_TIME < 1) $error("BLOCK_TIME must be positive");
    if (GAP_CYCLES < 1) $error("GAP_CYCLES must be positive");
    if (REPLY_WIDTH != DG) $error("REPLY_WIDTH must equal the datagram length");
  end

  // registers
  logic [31:0] configQ;
  logic [31:0] timingQ;
  logic [31:0] coverLowQ;
  logic [7:0]  coverHighQ;
  logic [31:0] replyLowQ;
  logic [7:0]  replyHighQ;
  logic        coverPendingQ;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      configQ    <= `SDP_CONFIG_RESET;
      timingQ    <= `SDP_TIMING_RESET;
      coverLowQ  <= 32'h0000_0000;
      coverHighQ <= 8'h00;
    end else if (regWr) begin
      case (regAddr)
        `SDP_ADDR_CONFIG:     configQ    <= regWrData;
        `SDP_ADDR_TIMING:     timingQ    <= regWrData;
        `SDP_ADDR_COVER_LOW:  coverLowQ  <= regWrData;
        `SDP_ADDR_COVER_HIGH: coverHighQ <= regWrData[7:0];
        default:              ;
      endcase
    end
  end

  assign stepDirTiming = timingQ;

  logic [3:0] fmt;
  logic       coverLenZero;
  logic [3:0] pollExp;
  logic       doneOnlyCovers;
  logic       pollDisabled;
  logic       scaleEnable;

  assign fmt            = configQ[`SDP_FMT_MSB:`SDP_FMT_LSB];
  assign coverLenZero   = (configQ[`SDP_COVER_LEN_MSB:`SDP_COVER_LEN_LSB] == '0);
  assign pollExp        = configQ[`SDP_POLL_EXP_MSB:`SDP_POLL_EXP_LSB];
  assign doneOnlyCovers = configQ[`SDP_DONE_COVERS_BIT];
  assign pollDisabled   = configQ[`SDP_POLL_DIS_BIT];
  assign scaleEnable    = configQ[`SDP_SCALE_EN_BIT];
  assign spiMode        = (fmt == `SDP_FMT_SPI_MODE) && coverLenZero;
  assign sdMode         = (fmt == `SDP_FMT_SD_MODE) && coverLenZero;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else begin
      case (regAddr)
        `SDP_ADDR_CONFIG:     regRdData <= configQ;
        `SDP_ADDR_TIMING:     regRdData <= timingQ;
        `SDP_ADDR_COVER_LOW:  regRdData <= replyLowQ;
        `SDP_ADDR_COVER_HIGH: regRdData <= {24'h00_0000, replyHighQ};
        default:              regRdData <= 32'h0000_0000;
      endcase
    end
  end

  // miso synchroniser
  logic misoMetaQ;
  logic misoSyncQ;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      misoMetaQ <= 1'b0;
      misoSyncQ <= 1'b0;
    end else begin
      misoMetaQ <= misoIn;
      misoSyncQ <= misoMetaQ;
    end
  end

  // reply buffer, two entries
  logic [REPLY_WIDTH-1:0] fifoMem [2];
  logic                   wrPtrQ;
  logic                   rdPtrQ;
  logic [1:0]             fifoCntQ;
  logic                   fifoPush;
  logic                   fifoPop;
  logic                   fifoFull;
  logic [DG-1:0]          rxShQ;

  assign fifoFull   = (fifoCntQ == 2'd2);
  assign replyValid = (fifoCntQ != 2'd0);
  assign fifoPop    = replyValid && replyReady;
  assign replyData  = fifoMem[rdPtrQ];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifoMem[0] <= '0;
      fifoMem[1] <= '0;
      wrPtrQ     <= 1'b0;
      rdPtrQ     <= 1'b0;
      fifoCntQ   <= 2'd0;
    end else begin
      if (fifoPush) begin
        // last bit is still on its way into the shifter at this edge
        fifoMem[wrPtrQ] <= {rxShQ[DG-2:0], misoSyncQ};
        wrPtrQ          <= ~wrPtrQ;
      end
      if (fifoPop) begin
        rdPtrQ <= ~rdPtrQ;
      end
      fifoCntQ <= fifoCntQ + {1'b0, fifoPush} - {1'b0, fifoPop};
    end
  end

  // poll interval timer
  logic [PCNTW-1:0] pollCntQ;
  logic [PCNTW-1:0] pollInterval;
  logic             pollDue;
  logic             pollEnable;
  logic             startPoll;

  assign pollEnable   = sdMode && !pollDisabled;
  assign pollInterval = PCNTW'(BLOCK_TIME) << pollExp;
  // start lands on the edge after due, so due is raised one count early
  assign pollDue      = pollEnable && (pollCntQ >= pollInterval - PCNTW'(1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pollCntQ <= '0;
    end else if (!pollEnable || startPoll) begin
      pollCntQ <= '0;
    end else if (!pollDue) begin
      pollCntQ <= pollCntQ + 1'b1;
    end
  end

  // arbitration: cover first, then current, scaling, polling
  sdp_state_t stateQ;
  sdp_kind_t  kindQ;
  sdp_kind_t  kindD;
  logic       canStart;
  logic       startAny;
  logic [DG-1:0] txD;

  assign canStart     = (stateQ == SDP_IDLE) && !fifoFull;
  assign currentReady = canStart && !coverPendingQ && spiMode;
  assign scaleReady   = canStart && !coverPendingQ && sdMode && scaleEnable;
  assign startPoll    = canStart && !coverPendingQ && pollDue
                        && !(sdMode && scaleEnable && scaleValid);
  assign startAny     = (canStart && coverPendingQ) || (currentReady && currentValid)
                        || (scaleReady && scaleValid) || startPoll;

  always_comb begin
    kindD = SDP_KIND_POLL;
    txD   = {`SDP_POLL_ADDR, 32'h0000_0000};
    if (coverPendingQ) begin
      kindD = SDP_KIND_COVER;
      txD   = {coverHighQ, coverLowQ};
    end else if (currentReady && currentValid) begin
      kindD = SDP_KIND_CURRENT;
      txD   = currentData;
    end else if (scaleReady && scaleValid) begin
      kindD = SDP_KIND_SCALE;
      txD   = scaleData;
    end
  end

  // cover request held until the engine takes it; a new write wins over the take
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coverPendingQ <= 1'b0;
    end else if (regWr && regAddr == `SDP_ADDR_COVER_LOW) begin
      coverPendingQ <= 1'b1;
    end else if (canStart && coverPendingQ) begin
      coverPendingQ <= 1'b0;
    end
  end

  // shift engine
  logic [DG-1:0]   txShQ;
  logic [BITW-1:0] bitCntQ;
  logic [DIVW-1:0] divCntQ;
  logic [GAPW-1:0] gapCntQ;
  logic            halfTick;
  logic            lastFall;

  assign halfTick = (stateQ == SDP_SHIFT) && (divCntQ == DIVW'(SCK_HALF - 1));
  assign lastFall = halfTick && sckOut && (bitCntQ == BITW'(DG - 1));
  assign fifoPush = lastFall;
  assign busy     = (stateQ != SDP_IDLE) || coverPendingQ;
  assign mosiOut  = txShQ[DG-1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateQ  <= SDP_IDLE;
      kindQ   <= SDP_KIND_POLL;
      txShQ   <= '0;
      rxShQ   <= '0;
      bitCntQ <= '0;
      divCntQ <= '0;
      gapCntQ <= '0;
      sckOut  <= 1'b0;
      csN     <= 1'b1;
    end else begin
      case (stateQ)
        SDP_IDLE: begin
          if (startAny) begin
            stateQ  <= SDP_SHIFT;
            kindQ   <= kindD;
            txShQ   <= txD;
            bitCntQ <= '0;
            divCntQ <= '0;
            csN     <= 1'b0;
          end
        end
        SDP_SHIFT: begin
          if (halfTick) begin
            divCntQ <= '0;
            sckOut  <= ~sckOut;
            if (sckOut) begin
              rxShQ <= {rxShQ[DG-2:0], misoSyncQ};
              txShQ <= {txShQ[DG-2:0], 1'b0};
              bitCntQ <= bitCntQ + 1'b1;
              if (lastFall) begin
                stateQ  <= SDP_GAP;
                gapCntQ <= '0;
                csN     <= 1'b1;
              end
            end
          end else begin
            divCntQ <= divCntQ + 1'b1;
          end
        end
        SDP_GAP: begin
          if (gapCntQ == GAPW'(GAP_CYCLES - 1)) begin
            stateQ <= SDP_IDLE;
          end else begin
            gapCntQ <= gapCntQ + 1'b1;
          end
        end
        default: begin
          stateQ <= SDP_IDLE;
          csN    <= 1'b1;
          sckOut <= 1'b0;
        end
      endcase
    end
  end

  // reply capture and done event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      replyLowQ  <= 32'h0000_0000;
      replyHighQ <= 8'h00;
    end else if (lastFall && kindQ == SDP_KIND_COVER) begin
      replyHighQ <= rxShQ[DG-2:DG-9];
      replyLowQ  <= {rxShQ[DG-10:0], misoSyncQ};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coverDone <= 1'b0;
    end else begin
      case (kindQ)
        SDP_KIND_COVER:   coverDone <= lastFall;
        SDP_KIND_CURRENT: coverDone <= lastFall && !doneOnlyCovers;
        SDP_KIND_POLL:    coverDone <= lastFall && !doneOnlyCovers;
        default:          coverDone <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: stepper_driver_spi_datagram_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdp_cfg.svh"
module stepper_driver_spi_datagram_port_bench;
  localparam int BT = 512;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        regWr = 1'b0;
  logic        currentValid = 1'b0;
  logic        scaleValid = 1'b0;
  logic        replyReady = 1'b1;
  logic        currentReady, scaleReady, replyValid, coverDone, spiMode, sdMode, busy;
  logic        sckOut, csN, mosiOut, misoIn, cs_q;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic [31:0] regRdData, stepDirTiming, rdv;
  logic [39:0] currentData = 40'h00_0000_0000;
  logic [39:0] scaleData = 40'h00_0000_0000;
  logic [39:0] replyData;
  int          bad_count = 0;
  int          comparisons = 0;
  int          doneCount = 0;
  int          cyc = 0;
  int          d0, lastFall, prevFall;
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    cyc++;
    if (coverDone === 1'b1) doneCount++;
    if (cs_q === 1'b1 && csN === 1'b0) begin
      prevFall = lastFall;
      lastFall = cyc;
    end
    cs_q = csN;
  end
  sdp_spi_datagram_port #(.BLOCK_TIME(BT)) u_sdp_spi_datagram_port (
    .clk(clk), .rst(rst), .regWr(regWr), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .stepDirTiming(stepDirTiming), .currentValid(currentValid),
    .currentReady(currentReady), .currentData(currentData), .scaleValid(scaleValid),
    .scaleReady(scaleReady), .scaleData(scaleData), .replyValid(replyValid),
    .replyReady(replyReady), .replyData(replyData), .coverDone(coverDone),
    .spiMode(spiMode), .sdMode(sdMode), .busy(busy), .sckOut(sckOut), .csN(csN),
    .mosiOut(mosiOut), .misoIn(misoIn)
  );
  sdp_drv_model u_sdp_drv_model (
    .clk(clk), .sckOut(sckOut), .csN(csN), .mosiOut(mosiOut), .misoIn(misoIn)
  );
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic stuck();
    bad_count++;
    $display("CHECK FAILED at %0t: timed out", $time);
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rdv = regRdData;
    @(posedge clk);
  endtask
  task automatic push(input logic sc, input logic [39:0] d);
    int i;
    scaleValid <= sc;
    currentValid <= !sc;
    scaleData <= d;
    currentData <= d;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if ((sc ? scaleReady : currentReady) === 1'b1) break;
    end
    if (i == 3000) stuck();
    @(posedge clk);
    scaleValid <= 1'b0;
    currentValid <= 1'b0;
  endtask
  task automatic waitFrames(input int n);
    int i;
    for (i = 0; i < 5000 && u_sdp_drv_model.frames < n; i++) @(posedge clk);
    if (u_sdp_drv_model.frames < n) stuck();
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [39:0] rep(input int n);
    return {8'hA5 ^ n[7:0], 24'h3C_960F, n[7:0]};
  endfunction
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'h20);
    check(40'(rdv), 40'h00_0000_0000);
    wr(`SDP_ADDR_TIMING, 32'h0000_1234);
    check(40'(stepDirTiming), 40'h00_0000_1234);
    wr(`SDP_ADDR_CONFIG, 32'h0000_000D);
    check(40'({spiMode, sdMode}), 40'h00_0000_0002);
    d0 = doneCount;
    push(1'b0, 40'h12_3456_789A);
    waitFrames(1);
    check(u_sdp_drv_model.lastRx, 40'h12_3456_789A);
    check(40'(doneCount - d0), 40'h00_0000_0001);
    replyReady <= 1'b0;
    push(1'b0, 40'h0F_0F0F_0F0F);
    wr(`SDP_ADDR_COVER_HIGH, 32'h0000_0042);
    wr(`SDP_ADDR_COVER_LOW, 32'hDEAD_BEEF);
    waitFrames(3);
    check(u_sdp_drv_model.lastRx, 40'h42_DEAD_BEEF);
    rd(`SDP_ADDR_COVER_HIGH);
    check(40'(rdv), 40'h00_0000_00A7);
    rd(`SDP_ADDR_COVER_LOW);
    check(40'(rdv), 40'h00_3C96_0F02);
    wr(`SDP_ADDR_COVER_LOW, 32'h0000_0001);
    repeat (400) @(posedge clk);
    check(40'(u_sdp_drv_model.frames), 40'h00_0000_0003);
    check(replyData, rep(1));
    replyReady <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(replyData, rep(2));
    waitFrames(4);
    check(u_sdp_drv_model.lastRx, 40'h42_0000_0001);
    wr(`SDP_ADDR_CONFIG, 32'h0000_100D);
    d0 = doneCount;
    push(1'b0, 40'h33_0000_0033);
    waitFrames(5);
    check(40'(doneCount - d0), 40'h00_0000_0000);
    wr(`SDP_ADDR_COVER_LOW, 32'h0000_0002);
    waitFrames(6);
    check(40'(doneCount - d0), 40'h00_0000_0001);
    wr(`SDP_ADDR_CONFIG, 32'h0000_006C);
    check(40'({spiMode, sdMode}), 40'h00_0000_0001);
    push(1'b1, 40'h55_0000_0011);
    waitFrames(7);
    check(u_sdp_drv_model.lastRx, 40'h55_0000_0011);
    check(40'(currentReady), 40'h00_0000_0000);
    wr(`SDP_ADDR_CONFIG, 32'h0000_012C);
    waitFrames(8);
    d0 = doneCount;
    waitFrames(10);
    check(u_sdp_drv_model.lastRx, {`SDP_POLL_ADDR, 32'h0000_0000});
    check(40'(lastFall - prevFall), 40'(BT * 2));
    check(40'(doneCount - d0), 40'h00_0000_0002);
    complete_run();
  end
endmodule
`default_nettype wire
